//--- rtl/usc_defines.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH
`define USC_RCV_OFF      8'h18
`define USC_XMT_OFF      8'h98
`define USC_DATA_OFF     8'h1C
`define USC_IRQ_ST_OFF   8'h20
`define USC_IRQ_MSK_OFF  8'h24
`define USC_BAUD_OFF     8'h28
`define USC_B_SERIAL_PORT_ENABLE       7
`define USC_B_RX9        6
`define USC_B_SINGLE_RECEIVE_ENABLE       5
`define USC_B_CONTINUOUS_RECEIVE_ENABLE       4
`define USC_B_FRAMING_ERROR_FLAG       2
`define USC_B_OVERRUN_ERROR_FLAG       1
`define USC_B_RECEIVED_NINTH_BIT       0
`define USC_B_CLOCK_SOURCE_SELECT       7
`define USC_B_TX9        6
`define USC_B_TRANSMIT_ENABLE       5
`define USC_B_SYNC       4
`define USC_B_HIGH_BAUD_SELECT       2
`define USC_B_SHIFT_REGISTER_EMPTY       1
`define USC_B_TRANSMIT_NINTH_BIT       0
`define USC_RCV_WMASK    8'hF0
`define USC_XMT_WMASK    8'hF5
`define USC_RD_MASK      8'hF7
`define USC_XMT_RST      8'h02
`define USC_BAUD_RST     8'h0F
`define USC_IRQ_RX       0
`define USC_IRQ_TX       1
`define USC_IRQ_FRAMING_ERROR_FLAG     2
`define USC_IRQ_OVERRUN_ERROR_FLAG     3
`define USC_OS_LOW       6'd63
`define USC_OS_HIGH      6'd15
`define USC_OS_SYNC      6'd3
`define USC_OKAY         2'b00
`define USC_SLVERR       2'b10
`endif

//--- rtl/usc_pkg.sv
// Types shared by the serial port control and status logic.
`default_nettype none
package usc_pkg;
	typedef enum logic [1:0] {
		USC_ASYNC,
		USC_SYNC_MASTER,
		USC_SYNC_SLAVE
	} usc_mode_t;
endpackage
`default_nettype wire

//--- rtl/usc_ev_if.sv
// Interface that carries receive and transmit events between the shifter and control.
`default_nettype none
interface usc_ev_if;
	logic       rx_done;
	logic [8:0] rx_word;
	logic       rx_framing_error_flag;
	logic       rx_active;
	logic       tx_busy;
	logic       tx_start;
	logic [8:0] tx_word;
	logic       nine_rx;
	logic       nine_tx;
	modport ctl (input rx_done, rx_word, rx_framing_error_flag, tx_busy, rx_active,
		output tx_start, tx_word, nine_rx, nine_tx);
	modport sh (output rx_done, rx_word, rx_framing_error_flag, tx_busy, rx_active,
		input tx_start, tx_word, nine_rx, nine_tx);
endinterface
`default_nettype wire

//--- rtl/usc_tick.sv
// Baud tick divider producing one-cycle enable pulses.
`default_nettype none
module usc_tick
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] div_i,
	input  wire logic             restart_i,
	output logic                  tick_o
);
	import usc_pkg::*;
	typedef struct packed
	{
		logic [WIDTH-1:0] cnt;
		logic             tick;
	} usc_tick_st_t;
	usc_tick_st_t st;
	usc_tick_st_t next_st;

	// Count down the divider and pulse on each wrap.
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (restart_i)
			next_st.cnt = div_i;
		else if (st.cnt == '0)
		begin
			next_st.cnt = div_i;
			next_st.tick = 1'b1;
		end
		else
			next_st.cnt = st.cnt - 1'b1;
	end

	// Register the divider state.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			st <= '0;
		else
			st <= next_st;
	end
	assign tick_o = st.tick;
endmodule
`default_nettype wire

//--- rtl/usc_top.sv
// Serial port control and status block with AXI4-Lite registers.
// Summary of operation
// - Modes are asynchronous full duplex, synchronous master, synchronous slave.
// - Receive control bit 7 enables the port and hands it the pins.
// - Receive control bit 6 selects nine-bit reception, else eight-bit.
// - Bit 5 requests one master reception; hardware clears it when done.
// - In asynchronous mode bit 4 enables continuous reception.
// - In synchronous mode continuous receive runs until cleared, over single.
// - Receive control bit 3 always reads zero.
// - Bit 2 framing error is refreshed by data read and next byte.
// - Bit 1 overrun stays set until continuous receive is cleared.
// - Bit 0 holds the ninth bit of the last received character.
// - Reset clears control and error bits, and the ninth bit reads zero.
`default_nettype none
`include "usc_defines.svh"
module usc_top
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        receive_data_pin_i,
	output logic             receive_data_pin_o,
	output logic             receive_data_pin_oe_o,
	input  wire logic        transmit_clock_pin_i,
	output logic             transmit_clock_pin_o,
	output logic             transmit_clock_pin_oe_o,
	output var usc_pkg::usc_mode_t mode_o,
	output logic             irq_o
);
	import usc_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed
	{
		logic       aw_held;
		logic [7:0] aw_addr;
		logic       w_held;
		logic [7:0] w_data;
		logic       w_lane0;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] rcv;
		logic [7:0] xmt;
		logic [8:0] rx_buf;
		logic       rx_full;
		logic       framing_error_flag_pend;
		logic [3:0] irq_st;
		logic [3:0] irq_msk;
		logic [7:0] baud;
		logic       baud_new;
		logic       tx_start;
		logic [8:0] tx_word;
		logic       irq;
		usc_mode_t  mode;
		logic       rx_pin_oe;
		logic       ck_pin_oe;
	} usc_st_t;
	usc_st_t st;
	usc_st_t next_st;

	usc_ev_if ev();
	logic tick;
	logic rx_ready;

	// Baud divider; a new divisor restarts it at once.
	usc_tick #(.WIDTH(8)) u_tick
	(
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.div_i     (st.baud),
		.restart_i (st.baud_new),
		.tick_o    (tick)
	);

	// Shift datapath behind the control logic.
	usc_shift u_shift
	(
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.tick_i      (tick),
		.enable_i    (st.rcv[`USC_B_SERIAL_PORT_ENABLE]),
		.mode_i      (st.mode),
		.high_baud_select_i      (st.xmt[`USC_B_HIGH_BAUD_SELECT]),
		.rx_enable_i (rx_ready),
		.rx_pin_i    (receive_data_pin_i),
		.ck_pin_i    (transmit_clock_pin_i),
		.tx_pin_o    (transmit_clock_pin_o),
		.dt_pin_o    (receive_data_pin_o),
		.ev          (ev.sh)
	);

	// Decode the mode from the sync and clock source bits.
	function automatic usc_mode_t mode_of(input logic [7:0] x);
		if (!x[`USC_B_SYNC])
			return USC_ASYNC;
		else if (x[`USC_B_CLOCK_SOURCE_SELECT])
			return USC_SYNC_MASTER;
		else
			return USC_SYNC_SLAVE;
	endfunction

	// Receiver runs on continuous enable, or single enable in master mode.
	assign rx_ready = st.rcv[`USC_B_SERIAL_PORT_ENABLE] & (st.rcv[`USC_B_CONTINUOUS_RECEIVE_ENABLE] |
		(st.mode == USC_SYNC_MASTER & st.rcv[`USC_B_SINGLE_RECEIVE_ENABLE]));
	assign ev.tx_start = st.tx_start;
	assign ev.tx_word  = st.tx_word;
	assign ev.nine_rx  = st.rcv[`USC_B_RX9];
	assign ev.nine_tx  = st.xmt[`USC_B_TX9];

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic       wr;
		logic       rd;
		logic [7:0] wa;
		logic [7:0] ra;
		logic [7:0] rv;
		logic       ok;
		logic       ovr;
		ovr = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		wa = 8'h00;
		ra = 8'h00;
		rv = 8'h00;
		ok = 1'b1;
		next_st = st;
		next_st.tx_start = 1'b0;
		next_st.baud_new = 1'b0;
		if (s_axi_awvalid_i && !st.aw_held)
		begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !st.w_held)
		begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata_i[7:0];
			next_st.w_lane0 = s_axi_wstrb_i[0];
		end
		if (st.bvalid && s_axi_bready_i)
			next_st.bvalid = 1'b0;
		if (st.rvalid && s_axi_rready_i)
			next_st.rvalid = 1'b0;
		wr = st.aw_held & st.w_held & ~st.bvalid;
		wa = {st.aw_addr[7:2], 2'b00};
		rd = s_axi_arvalid_i & ~st.rvalid;
		ra = {s_axi_araddr_i[7:2], 2'b00};
		// Read side effects come first so a same-cycle event still sets.
		if (rd && ra == `USC_IRQ_ST_OFF)
			next_st.irq_st = 4'h0;
		if (rd && ra == `USC_DATA_OFF)
		begin
			next_st.rx_full = 1'b0;
			next_st.rcv[`USC_B_FRAMING_ERROR_FLAG] = 1'b0;
		end
		// Hardware events then set flags over any software clear.
		if (ev.rx_done)
		begin
			if (next_st.rx_full)
			begin
				ovr = 1'b1;
				next_st.rcv[`USC_B_OVERRUN_ERROR_FLAG] = 1'b1;
				next_st.irq_st[`USC_IRQ_OVERRUN_ERROR_FLAG] = 1'b1;
			end
			else
			begin
				next_st.rx_buf = ev.rx_word;
				next_st.rx_full = 1'b1;
				next_st.rcv[`USC_B_RECEIVED_NINTH_BIT] = ev.rx_word[8];
				next_st.framing_error_flag_pend = ev.rx_framing_error_flag;
				next_st.rcv[`USC_B_FRAMING_ERROR_FLAG] = ev.rx_framing_error_flag;
				next_st.irq_st[`USC_IRQ_RX] = 1'b1;
				if (ev.rx_framing_error_flag)
					next_st.irq_st[`USC_IRQ_FRAMING_ERROR_FLAG] = 1'b1;
			end
			if (st.mode == USC_SYNC_MASTER && !st.rcv[`USC_B_CONTINUOUS_RECEIVE_ENABLE])
				next_st.rcv[`USC_B_SINGLE_RECEIVE_ENABLE] = 1'b0;
		end
		next_st.xmt[`USC_B_SHIFT_REGISTER_EMPTY] = ~ev.tx_busy & ~st.tx_start;
		if (ev.tx_busy && !st.xmt[`USC_B_SHIFT_REGISTER_EMPTY])
			next_st.irq_st[`USC_IRQ_TX] = next_st.irq_st[`USC_IRQ_TX];
		if (!ev.tx_busy && !st.xmt[`USC_B_SHIFT_REGISTER_EMPTY] && !st.tx_start)
			next_st.irq_st[`USC_IRQ_TX] = 1'b1;
		// Register writes.
		if (wr)
		begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `USC_OKAY;
			if (st.w_lane0)
			begin
				unique case (wa)
					`USC_RCV_OFF:
					begin
						next_st.rcv = (st.w_data & `USC_RCV_WMASK) |
							(next_st.rcv & ~`USC_RCV_WMASK);
						if (!st.w_data[`USC_B_CONTINUOUS_RECEIVE_ENABLE] && !ovr)
							next_st.rcv[`USC_B_OVERRUN_ERROR_FLAG] = 1'b0;
					end
					`USC_XMT_OFF:
						next_st.xmt = (st.w_data & `USC_XMT_WMASK) |
							(next_st.xmt & ~`USC_XMT_WMASK);
					`USC_IRQ_MSK_OFF:
						next_st.irq_msk = st.w_data[3:0];
					`USC_BAUD_OFF:
					begin
						next_st.baud = st.w_data;
						next_st.baud_new = 1'b1;
					end
					`USC_DATA_OFF:
						if (st.xmt[`USC_B_TRANSMIT_ENABLE] && st.xmt[`USC_B_SHIFT_REGISTER_EMPTY])
						begin
							next_st.tx_start = 1'b1;
							next_st.tx_word = {st.xmt[`USC_B_TRANSMIT_NINTH_BIT], st.w_data};
							next_st.xmt[`USC_B_SHIFT_REGISTER_EMPTY] = 1'b0;
						end
					default:
						ok = 1'b0;
				endcase
			end
			if (!ok)
				next_st.bresp = `USC_SLVERR;
		end
		// Register reads.
		if (rd)
		begin
			ok = 1'b1;
			unique case (ra)
				`USC_RCV_OFF:
					rv = st.rcv & `USC_RD_MASK;
				`USC_XMT_OFF:
					rv = st.xmt & `USC_RD_MASK;
				`USC_DATA_OFF:
					rv = st.rx_buf[7:0];
				`USC_IRQ_ST_OFF:
					rv = {4'h0, st.irq_st};
				`USC_IRQ_MSK_OFF:
					rv = {4'h0, st.irq_msk};
				`USC_BAUD_OFF:
					rv = st.baud;
				default:
					ok = 1'b0;
			endcase
			next_st.rvalid = 1'b1;
			next_st.rdata = {24'h000000, rv};
			next_st.rresp = ok ? `USC_OKAY : `USC_SLVERR;
		end
		next_st.mode = mode_of(next_st.xmt);
		// Port takes the pins only when enabled.
		next_st.rx_pin_oe = next_st.rcv[`USC_B_SERIAL_PORT_ENABLE] &
			(next_st.mode != USC_ASYNC) & ev.tx_busy;
		next_st.ck_pin_oe = next_st.rcv[`USC_B_SERIAL_PORT_ENABLE] &
			((next_st.mode == USC_ASYNC) |
			(next_st.mode == USC_SYNC_MASTER));
		next_st.irq = |(next_st.irq_st & next_st.irq_msk);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= '0;
			st.xmt <= `USC_XMT_RST;
			st.baud <= `USC_BAUD_RST;
		end
		else
			st <= next_st;
	end

	// Outputs come straight from the state register.
	assign s_axi_awready_o = ~st.aw_held;
	assign s_axi_wready_o = ~st.w_held;
	assign s_axi_bvalid_o = st.bvalid;
	assign s_axi_bresp_o = st.bresp;
	assign s_axi_arready_o = ~st.rvalid;
	assign s_axi_rvalid_o = st.rvalid;
	assign s_axi_rdata_o = st.rdata;
	assign s_axi_rresp_o = st.rresp;
	assign receive_data_pin_oe_o = st.rx_pin_oe;
	assign transmit_clock_pin_oe_o = st.ck_pin_oe;
	assign mode_o = st.mode;
	assign irq_o = st.irq;
endmodule
`default_nettype wire

//--- rtl/usc_shift.sv
// Minimal receive and transmit shifter for the serial port.
`default_nettype none
`include "usc_defines.svh"
module usc_shift
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        tick_i,
	input  wire logic        enable_i,
	input  wire usc_pkg::usc_mode_t mode_i,
	input  wire logic        high_baud_select_i,
	input  wire logic        rx_enable_i,
	input  wire logic        rx_pin_i,
	input  wire logic        ck_pin_i,
	output logic             tx_pin_o,
	output logic             dt_pin_o,
	usc_ev_if.sh             ev
);
	import usc_pkg::*;
	typedef struct packed
	{
		logic [1:0] rx_sync;
		logic [1:0] ck_sync;
		logic       ck_last;
		logic       rx_busy;
		logic [5:0] rx_os;
		logic [3:0] rx_bits;
		logic [9:0] rx_sh;
		logic       done;
		logic       framing_error_flag;
		logic       tx_busy;
		logic [5:0] tx_os;
		logic [3:0] tx_bits;
		logic [10:0] tx_sh;
		logic       ck_out;
	} usc_sh_st_t;
	usc_sh_st_t st;
	usc_sh_st_t next_st;

	// Oversample count per bit for the present mode.
	function automatic logic [5:0] os_of(input usc_mode_t m, input logic h);
		if (m != USC_ASYNC)
			return `USC_OS_SYNC;
		else
			return h ? `USC_OS_HIGH : `USC_OS_LOW;
	endfunction

	// Async frames: start, data, optional ninth, stop; sync frames clock data.
	always_comb
	begin
		logic [3:0] nbits;
		logic       ck_rise;
		nbits = (ev.nine_rx ? 4'd8 : 4'd7) +
			((mode_i == USC_ASYNC) ? 4'd2 : 4'd0);
		ck_rise = st.ck_sync[1] & ~st.ck_last;
		next_st = st;
		next_st.rx_sync = {st.rx_sync[0], rx_pin_i};
		next_st.ck_sync = {st.ck_sync[0], ck_pin_i};
		next_st.ck_last = st.ck_sync[1];
		next_st.done = 1'b0;
		if (!enable_i || !rx_enable_i)
			next_st.rx_busy = 1'b0;
		else if (!st.rx_busy)
		begin
			if (mode_i == USC_ASYNC ? !st.rx_sync[1] : 1'b1)
			begin
				next_st.rx_busy = 1'b1;
				next_st.rx_os = os_of(mode_i, high_baud_select_i) >> 1;
				next_st.rx_bits = 4'd0;
			end
		end
		else if ((mode_i == USC_SYNC_SLAVE) ? ck_rise : tick_i)
		begin
			if (st.rx_os != 6'd0 && mode_i != USC_SYNC_SLAVE)
				next_st.rx_os = st.rx_os - 6'd1;
			else
			begin
				next_st.rx_os = os_of(mode_i, high_baud_select_i);
				// The async stop bit is checked, not shifted into the word.
				if (st.rx_bits != nbits || mode_i != USC_ASYNC)
					next_st.rx_sh = {st.rx_sync[1], st.rx_sh[9:1]};
				next_st.rx_bits = st.rx_bits + 4'd1;
				if (st.rx_bits == nbits)
				begin
					next_st.rx_busy = 1'b0;
					next_st.done = 1'b1;
					next_st.framing_error_flag = (mode_i == USC_ASYNC) & ~st.rx_sync[1];
				end
			end
		end
		if (ev.tx_start)
		begin
			next_st.tx_busy = 1'b1;
			next_st.tx_sh = {1'b1, ev.tx_word[8] | ~ev.nine_tx,
				ev.tx_word[7:0], 1'b0};
			next_st.tx_bits = ev.nine_tx ? 4'd11 : 4'd10;
			next_st.tx_os = os_of(mode_i, high_baud_select_i);
		end
		else if (st.tx_busy && tick_i)
		begin
			if (st.tx_os != 6'd0)
				next_st.tx_os = st.tx_os - 6'd1;
			else
			begin
				next_st.tx_os = os_of(mode_i, high_baud_select_i);
				next_st.tx_sh = {1'b1, st.tx_sh[10:1]};
				next_st.tx_bits = st.tx_bits - 4'd1;
				next_st.ck_out = ~st.ck_out;
				if (st.tx_bits == 4'd1)
					next_st.tx_busy = 1'b0;
			end
		end
	end

	// Register the shifter state; the line idles high.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= '0;
			st.tx_sh <= 11'h7FF;
			st.rx_sync <= 2'b11; // Idle high, so no false start bit.
		end
		else
			st <= next_st;
	end
	assign ev.rx_done = st.done;
	assign ev.rx_word = ev.nine_rx ? st.rx_sh[9:1] : {1'b0, st.rx_sh[9:2]};
	assign ev.rx_framing_error_flag = st.framing_error_flag;
	assign ev.rx_active = st.rx_busy;
	assign ev.tx_busy = st.tx_busy;
	assign tx_pin_o = (mode_i == USC_ASYNC) ? st.tx_sh[0] : st.ck_out;
	assign dt_pin_o = st.tx_sh[0];
endmodule
`default_nettype wire

//--- bench/usc_top_asserts.sv
// Concurrent checks on the ports of the serial port control block.
`default_nettype none
// ********************************************************************
// Port checker
// ********************************************************************
module usc_top_asserts
(
	input wire logic               clk_sys_i,
	input wire logic               rst_i,
	input wire logic [7:0]         s_axi_awaddr_i,
	input wire logic               s_axi_awvalid_i,
	input wire logic               s_axi_awready_o,
	input wire logic [31:0]        s_axi_wdata_i,
	input wire logic               s_axi_wvalid_i,
	input wire logic               s_axi_wready_o,
	input wire logic               s_axi_bvalid_o,
	input wire logic               s_axi_bready_i,
	input wire logic [7:0]         s_axi_araddr_i,
	input wire logic               s_axi_arvalid_i,
	input wire logic               s_axi_arready_o,
	input wire logic [31:0]        s_axi_rdata_o,
	input wire logic [1:0]         s_axi_rresp_o,
	input wire logic               s_axi_rvalid_o,
	input wire logic               s_axi_rready_i,
	input wire logic               transmit_clock_pin_oe_o,
	input wire usc_pkg::usc_mode_t mode_o
);
	import usc_pkg::*;
	logic      aw_go;
	logic      w_go;
	logic      ar_go;
	logic      xmt_wr;
	logic [7:0] rd_addr;
	logic      serial_port_enable_q;
	usc_mode_t mode_want;
	default clocking dc @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// Handshake decodes.
	assign aw_go = s_axi_awvalid_i && s_axi_awready_o;
	assign w_go = s_axi_wvalid_i && s_axi_wready_o;
	assign ar_go = s_axi_arvalid_i && s_axi_arready_o;
	assign xmt_wr = aw_go && w_go && s_axi_awaddr_i == 8'h98;
	// Remember the read address, the enable bit and the requested mode.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_addr <= 8'h00;
			serial_port_enable_q <= 1'b0;
			mode_want <= USC_ASYNC;
		end
		else
		begin
			if (ar_go)
				rd_addr <= s_axi_araddr_i;
			if (aw_go && w_go && s_axi_awaddr_i == 8'h18)
				serial_port_enable_q <= s_axi_wdata_i[7];
			if (xmt_wr)
				mode_want <= !s_axi_wdata_i[4] ? USC_ASYNC :
					(s_axi_wdata_i[7] ? USC_SYNC_MASTER : USC_SYNC_SLAVE);
		end
	end
	bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o) else $error("Write response dropped early.");
	rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("Read data not held.");
	write_answer_a: assert property (aw_go && w_go |-> ##[1:3] s_axi_bvalid_o)
		else $error("Write response late.");
	read_answer_a: assert property (ar_go |-> ##[1:2] s_axi_rvalid_o)
		else $error("Read data late.");
	upper_zero_a: assert property (s_axi_rvalid_o
		|-> s_axi_rdata_o[31:8] == 24'h000000) else $error("Upper bits set.");
	unimpl_bit_a: assert property (
		s_axi_rvalid_o && (rd_addr == 8'h18 || rd_addr == 8'h98)
		|-> !s_axi_rdata_o[3]) else $error("Bit 3 reads one.");
	unmapped_err_a: assert property (s_axi_rvalid_o && rd_addr[7:6] == 2'b01
		|-> s_axi_rresp_o == 2'b10) else $error("No error response.");
	mode_follow_a: assert property (xmt_wr |=> ##[0:3] mode_o == mode_want)
		else $error("Mode does not follow control write.");
	pins_off_a: assert property (!serial_port_enable_q && !$past(serial_port_enable_q, 4)
		|-> !transmit_clock_pin_oe_o) else $error("Pin driven while off.");
	cover property (xmt_wr ##[1:4] mode_o == USC_SYNC_MASTER);
	cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10);
	cover property ($rose(transmit_clock_pin_oe_o));
endmodule
bind usc_top usc_top_asserts chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .mode_o(mode_o),
	.transmit_clock_pin_oe_o(transmit_clock_pin_oe_o));
`default_nettype wire

//--- bench/usc_link_model.sv
// Behavioural model of the external synchronous serial partner.
`default_nettype none
module usc_link_model
(
	output var logic ser_clk_o,
	output var logic ser_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock stands low between frames; the data line starts high.
	initial
	begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b1;
	end
	// Send a frame least significant bit first; data settles mid low phase.
	task automatic send(input logic [8:0] w, input int n);
		#3;
		for (int i = 0; i < n; i++)
		begin
			ser_data_o = w[i];
			#40 ser_clk_o = 1'b1;
			#80 ser_clk_o = 1'b0;
			#40;
		end
		// Released line keeps no value, so show the inverse of the last bit.
		ser_data_o = ~w[n-1];
	endtask
endmodule
`default_nettype wire

//--- bench/tb_usc_top.sv
// Self-checking testbench for the serial port control and status block.
`default_nettype none
`include "usc_defines.svh"
module tb_usc_top;
	timeunit 1ns;
	timeprecision 1ps;
	import usc_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, r, wb;
	logic        rx_pin, rx_o, rx_oe, ck_pin, ck_o, ck_oe, lk_clk, lk_data;
	usc_mode_t   mode;
	int          errors = 0;
	int          comparisons = 0;
	logic [7:0]  xw [3] = '{8'hF5, 8'h55, 8'h08};
	logic [31:0] xr [3] = '{32'hF7, 32'h57, 32'h02};
	logic [31:0] xm [3] = '{32'h1, 32'h2, 32'h0};
	// Clock and wire resolution of the shared pins.
	always #5 clk_sys_i = ~clk_sys_i;
	assign rx_pin = rx_oe ? rx_o : lk_data;
	assign ck_pin = ck_oe ? ck_o : lk_clk;
	usc_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .receive_data_pin_i(rx_pin),
		.receive_data_pin_o(rx_o), .receive_data_pin_oe_o(rx_oe),
		.transmit_clock_pin_i(ck_pin), .transmit_clock_pin_o(ck_o),
		.transmit_clock_pin_oe_o(ck_oe), .mode_o(mode), .irq_o(irq));
	usc_link_model link_u (.ser_clk_o(lk_clk), .ser_data_o(lk_data));
	// Compare and count.
	task automatic check(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Register write; address and data offered together. Handshakes are
	// sampled at the falling edge, so each release follows its own edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int   n;
		logic ta;
		logic tw;
		logic tk;
		n = 0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge clk_sys_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tk = bvalid;
			wb = bresp;
			@(posedge clk_sys_i);
			n++;
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!tk && n < 100);
		bready <= 1'b0;
		@(posedge clk_sys_i);
		if (n >= 100)
			errors++;
	endtask
	// Register read returning data and response.
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] e);
		int   n;
		logic ta;
		logic tk;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge clk_sys_i);
			ta = arvalid && arready;
			tk = rvalid;
			d = rdata;
			e = rresp;
			@(posedge clk_sys_i);
			n++;
			if (ta)
				arvalid <= 1'b0;
		end
		while (!tk && n < 100);
		rready <= 1'b0;
		@(posedge clk_sys_i);
		if (n >= 100)
			errors++;
	endtask
	// Read repeatedly until the masked value matches, bounded.
	task automatic poll(input logic [7:0] a, input logic [31:0] m, w);
		int n;
		n = 0;
		do
		begin
			rd(a, v, r);
			n++;
		end
		while ((v & m) !== w && n < 300);
		if (n >= 300)
			errors++;
	endtask
	// Print counts and verdict, then stop.
	task automatic print_verdict();
		$display("Comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog against a hung handshake.
	initial
	begin
		#300000;
		errors++;
		print_verdict();
	end
	// Main sequence.
	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		rd(`USC_RCV_OFF, v, r);
		check("rcv_reset", v & 32'hFE, 32'h00);
		rd(`USC_XMT_OFF, v, r);
		check("xmt_reset", v, 32'h02);
		rd(`USC_BAUD_OFF, v, r);
		check("baud_reset", v, 32'h0F);
		rd(8'h40, v, r);
		check("unmapped", {30'h0, r}, 32'h2);
		wr(8'h40, 8'h00);
		check("bresp_err", {30'h0, wb}, 32'h2);
		wr(`USC_RCV_OFF, 8'hFF);
		check("bresp_ok", {30'h0, wb}, 32'h0);
		rd(`USC_RCV_OFF, v, r);
		check("rcv_fields", v & 32'hFE, 32'hF0);
		wr(`USC_RCV_OFF, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			wr(`USC_XMT_OFF, xw[i]);
			rd(`USC_XMT_OFF, v, r);
			check("xmt_fields", v, xr[i]);
			check("mode", {30'h0, mode}, xm[i]);
		end
		// Synchronous slave, nine-bit continuous reception with overrun.
		wr(`USC_XMT_OFF, 8'h10);
		wr(`USC_IRQ_MSK_OFF, 8'h01);
		wr(`USC_RCV_OFF, 8'hD0);
		link_u.send(9'h1A5, 9);
		poll(`USC_RCV_OFF, 32'h01, 32'h01);
		check("ninth_bit", v, 32'hD1);
		check("irq_raised", {31'h0, irq}, 32'h1);
		link_u.send(9'h1C3, 9);
		poll(`USC_RCV_OFF, 32'h02, 32'h02);
		check("overrun_set", v, 32'hD3);
		rd(`USC_IRQ_ST_OFF, v, r);
		check("irq_status", v, 32'h09);
		rd(`USC_IRQ_ST_OFF, v, r);
		check("irq_clear", v, 32'h00);
		check("irq_low", {31'h0, irq}, 32'h0);
		wr(`USC_RCV_OFF, 8'hC0);
		rd(`USC_RCV_OFF, v, r);
		check("overrun_clr", v, 32'hC1);
		// Asynchronous transmit, then drain the receive buffer.
		wr(`USC_BAUD_OFF, 8'h00);
		wr(`USC_XMT_OFF, 8'h20);
		wr(`USC_DATA_OFF, 8'h5A);
		rd(`USC_XMT_OFF, v, r);
		check("shifting", v, 32'h20);
		check("start_bit", {31'h0, ck_o}, 32'h0);
		poll(`USC_XMT_OFF, 32'h02, 32'h02);
		check("line_idle", {31'h0, ck_o}, 32'h1);
		rd(`USC_IRQ_ST_OFF, v, r);
		check("tx_done", v, 32'h02);
		rd(`USC_DATA_OFF, v, r);
		check("rx_data", v, 32'hA5);
		// Synchronous master, single reception clears its own request.
		wr(`USC_RCV_OFF, 8'h00);
		wr(`USC_BAUD_OFF, 8'h00);
		wr(`USC_XMT_OFF, 8'h90);
		check("pins_off", {31'h0, ck_oe}, 32'h0);
		wr(`USC_RCV_OFF, 8'hA0);
		check("pins_on", {31'h0, ck_oe}, 32'h1);
		poll(`USC_RCV_OFF, 32'h20, 32'h00);
		check("single_done", v & 32'hF0, 32'h80);
		print_verdict();
	end
endmodule
`default_nettype wire
